/* File: src/rwdc_pkg.sv */
package rwdc_pkg;

    // ======================================================================
    // register map (byte addresses on the apb bus)
    // ======================================================================
    localparam int unsigned ADDR_W           = 8;
    localparam logic [7:0]  OFF_CTRL         = 8'h00;   // watchdog_control_register
    localparam logic [7:0]  OFF_STAT         = 8'h04;   // sticky interrupt status, read clears
    localparam logic [7:0]  OFF_MASK         = 8'h08;   // interrupt mask, same layout as status

    // watchdog_control_register fields
    localparam int unsigned CTL_SEL_LSB      = 0;       // two bits, timeout interval select
    localparam int unsigned CTL_IRQ_EN       = 2;       // early watchdog interrupt enable
    localparam int unsigned CTL_RESTART      = 3;       // write 1 restarts the counter, reads 0
    localparam int unsigned CTL_WD_FLAG      = 4;       // watchdog_reset_flag, write 1 clears
    localparam int unsigned CTL_POR_FLAG     = 5;       // power-on / brownout flag, write 1 clears
    localparam int unsigned CTL_EXT_FLAG     = 6;       // external pin reset flag, write 1 clears
    localparam int unsigned CTL_PIN_DIS      = 7;       // reset_pin_disable
    localparam int unsigned CTL_BOD_STOP_DIS = 8;       // brownout ignored while in stop mode
    localparam int unsigned CTL_CLK_RING     = 9;       // 1 = ring oscillator is system clock
    localparam int unsigned CTL_W            = 10;

    // status / mask fields
    localparam int unsigned STA_WD_EARLY     = 0;       // watchdog early warning
    localparam int unsigned STA_BOD_IGN      = 1;       // supply low seen while brownout ignored
    localparam int unsigned STA_W            = 2;

    // reset values
    localparam logic [1:0]  SEL_RST          = 2'h0;
    localparam logic        IRQ_EN_RST       = 1'b0;
    localparam logic        PIN_DIS_RST      = 1'b0;
    localparam logic        BOD_STOP_DIS_RST = 1'b0;
    localparam logic        CLK_RING_RST     = 1'b1;
    localparam logic        POR_FLAG_RST     = 1'b1;
    localparam logic [1:0]  STAT_RST         = 2'h0;
    localparam logic [1:0]  MASK_RST         = 2'h0;

    // ======================================================================
    // timing
    // ======================================================================
    localparam logic [15:0] RESTART_VECTOR   = 16'h8000;
    localparam int unsigned WD_EXP0          = 12;      // interval exponents, system clocks
    localparam int unsigned WD_EXP1          = 15;
    localparam int unsigned WD_EXP2          = 18;
    localparam int unsigned WD_EXP3          = 21;
    localparam int unsigned WD_EARLY         = 512;     // interrupt lead before the reset
    localparam int unsigned WD_CNT_W         = 22;
    localparam logic [2:0]  RST_HOLD_CYCLES  = 3'h4;    // cycles in hold after sources drop; one release cycle follows

    // reset sequencer states, gray along hold -> release -> run
    typedef enum logic [1:0]
    {
        ST_HOLD    = 2'h0,
        ST_RELEASE = 2'h1,
        ST_RUN     = 2'h3
    } rwdc_state_t;

    // length of the selected interval; the terminal count is one less
    function automatic int unsigned wd_limit(input logic [1:0] sel, input int unsigned e0,
                                             input int unsigned e1, input int unsigned e2,
                                             input int unsigned e3);
        int unsigned e;
        case (sel)
            2'h0:    e = e0;
            2'h1:    e = e1;
            2'h2:    e = e2;
            default: e = e3;
        endcase
        return 32'd1 << e;
    endfunction

endpackage

/* File: src/rwdc_wd_if.sv */
`timescale 1ns/100ps
// link between the reset sequencer and the watchdog counter
interface rwdc_wd_if;
    logic       clear;      // hold counter at zero
    logic       restart;    // software restart strobe
    logic [1:0] sel;        // interval select
    logic       early;      // early warning point reached
    logic       timeout;    // terminal count reached
    modport ctl (output clear, output restart, output sel, input early, input timeout);
    modport cnt (input clear, input restart, input sel, output early, output timeout);
endinterface

/* File: src/rwdc_wdog.sv */
`timescale 1ns/100ps
module rwdc_wdog
    import rwdc_pkg::*;
#(
    parameter int unsigned E0    = WD_EXP0,
    parameter int unsigned E1    = WD_EXP1,
    parameter int unsigned E2    = WD_EXP2,
    parameter int unsigned E3    = WD_EXP3,
    parameter int unsigned CNT_W = WD_CNT_W
)
(
    // clock and reset
    input  wire logic i_clk,
    input  wire logic i_rst_n,
    input  wire logic i_ce,
    // sequencer side
    rwdc_wd_if.cnt    wd
);

    // ======================================================================
    // up-counter, holds at the terminal count
    // ======================================================================
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] next_count;
    logic [CNT_W-1:0] term;
    logic [CNT_W-1:0] warn;

    // interval changes take effect on the running count, so a shorter pick below the count runs on through the 22-bit wrap first
    always_comb
    begin
        term       = CNT_W'(wd_limit(wd.sel, E0, E1, E2, E3) - 32'd1);
        warn       = CNT_W'(wd_limit(wd.sel, E0, E1, E2, E3) - WD_EARLY - 32'd1);
        next_count = count;
        if (wd.clear || wd.restart)
            next_count = '0;
        else if (count != term)
            next_count = count + CNT_W'(1);
    end

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            count <= '0;
        else if (i_ce)
            count <= next_count;
    end

    // both points come from one counter, so they stay exactly the lead apart
    assign wd.early   = !wd.clear && !wd.restart && (count == warn);
    assign wd.timeout = !wd.clear && !wd.restart && (count == term);

endmodule

/* File: src/rwdc_top.sv */
`timescale 1ns/100ps
// Summary of operation
// - Reset halts execution; high-frequency and ring oscillators keep running.
// - Supply below threshold forces reset; optionally ignored in stop mode.
// - Power-on reset restores registers, pins, and sets the power-on flag.
// - Power-on reset selects ring oscillator and starts crystal warmup.
// - Execution starts at 8000h when power-on reset ends.
// - Watchdog reset sets watchdog_reset_flag, readable by software.
// - Execution resumes at 8000h after watchdog reset.
// - External pin low resets; release restarts at 8000h.
// - Pin reset enabled after power-on; reset_pin_disable frees pin.
// - Watchdog terminal count forces full reset, optional interrupt first.
// - Four selectable timeouts from 2^12 to 2^21 system clocks.
// - Watchdog interrupt comes exactly 512 clocks before the reset.
module rwdc_top
    import rwdc_pkg::*;
#(
    parameter int unsigned P_WD_EXP0 = WD_EXP0,
    parameter int unsigned P_WD_EXP1 = WD_EXP1,
    parameter int unsigned P_WD_EXP2 = WD_EXP2,
    parameter int unsigned P_WD_EXP3 = WD_EXP3
)
(
    // clock, reset, enable
    input  wire logic              I_CLOCK,
    input  wire logic              I_RST_N,
    input  wire logic              I_CE,
    // apb slave
    input  wire logic              I_PSEL,
    input  wire logic              I_PENABLE,
    input  wire logic              I_PWRITE,
    input  wire logic [ADDR_W-1:0] I_PADDR,
    input  wire logic [31:0]       I_PWDATA,
    output logic      [31:0]       O_PRDATA,
    output logic                   O_PREADY,
    output logic                   O_PSLVERR,
    // reset sources
    input  wire logic              I_SUPPLY_OK,
    input  wire logic              I_STOP_MODE,
    input  wire logic              I_EXT_RST_N,
    // core and clock control
    output logic                   O_CPU_HALT,
    output logic                   O_SYS_RST_N,
    output logic                   O_FETCH_START,
    output logic      [15:0]       O_FETCH_ADDR,
    output logic                   O_HFOSC_EN,
    output logic                   O_RINGOSC_EN,
    output logic                   O_CLK_SEL_RING,
    output logic                   O_WARMUP_START,
    output logic                   O_RSTPIN_GPIO,
    // interrupt
    output logic                   O_IRQ
);

    // ======================================================================
    // input synchronisers
    // ======================================================================
    logic [1:0] supply_sync, ext_sync;
    logic       supply_ok, ext_pin_n;

    // both inputs are asynchronous to the system clock; only the second stage is read
    always_ff @(posedge I_CLOCK or negedge I_RST_N)
    begin
        if (!I_RST_N)
            {supply_sync, ext_sync} <= 4'h0;
        else if (I_CE)
            {supply_sync, ext_sync} <= {supply_sync[0], I_SUPPLY_OK, ext_sync[0], I_EXT_RST_N};
    end
    assign supply_ok = supply_sync[1];
    assign ext_pin_n = ext_sync[1];

    // ======================================================================
    // watchdog counter
    // ======================================================================
    rwdc_wd_if wd ();

    rwdc_wdog #(
        .E0    (P_WD_EXP0),
        .E1    (P_WD_EXP1),
        .E2    (P_WD_EXP2),
        .E3    (P_WD_EXP3),
        .CNT_W (WD_CNT_W)
    ) u_wdog (
        .i_clk   (I_CLOCK),
        .i_rst_n (I_RST_N),
        .i_ce    (I_CE),
        .wd      (wd.cnt)
    );

    // ======================================================================
    // sequencer and registers
    // ======================================================================
    rwdc_state_t state, next_state;
    logic [2:0]  hold_cnt, next_hold_cnt;
    logic        por_pend, next_por_pend;
    logic [1:0]  sel, next_sel;
    logic        irq_en, next_irq_en;
    logic        wd_flag, next_wd_flag;
    logic        por_flag, next_por_flag;
    logic        ext_flag, next_ext_flag;
    logic        pin_dis, next_pin_dis;
    logic        bod_stop_dis, next_bod_stop_dis;
    logic        clk_ring, next_clk_ring;
    logic [1:0]  stat, next_stat;
    logic [1:0]  mask, next_mask;
    logic        fetch, next_fetch;
    logic        warm, next_warm;
    logic        halt, next_halt;
    logic        irq, next_irq;

    logic        access, wr_ctrl, wr_mask, rd_stat;
    logic        src_bod, src_ext, src_wd, any_src;
    logic [1:0]  set_stat;
    logic [31:0] prdata, next_prdata;

    // bus strobes only act at the completing access cycle
    assign access  = I_PSEL && I_PENABLE && I_CE;
    assign wr_ctrl = access && I_PWRITE && (I_PADDR == OFF_CTRL);
    assign wr_mask = access && I_PWRITE && (I_PADDR == OFF_MASK);
    assign rd_stat = access && !I_PWRITE && (I_PADDR == OFF_STAT);

    // reset sources
    assign src_bod = !supply_ok && !(I_STOP_MODE && bod_stop_dis);
    assign src_ext = !ext_pin_n && !pin_dis;
    assign src_wd  = wd.timeout && (state == ST_RUN);
    assign any_src = src_bod || src_ext || src_wd;

    // watchdog interface drive
    assign wd.clear   = (state != ST_RUN);
    assign wd.restart = wr_ctrl && I_PWDATA[CTL_RESTART];
    assign wd.sel     = sel;

    // events for the sticky status
    always_comb
    begin
        set_stat               = 2'h0;
        set_stat[STA_WD_EARLY] = wd.early && irq_en && (state == ST_RUN);
        set_stat[STA_BOD_IGN]  = !supply_ok && I_STOP_MODE && bod_stop_dis;
    end

    // next state of sequencer and registers; hardware sets win over software clears
    always_comb
    begin
        next_state        = state;
        next_hold_cnt     = hold_cnt;
        next_por_pend     = por_pend;
        next_sel          = sel;
        next_irq_en       = irq_en;
        next_wd_flag      = wd_flag;
        next_por_flag     = por_flag;
        next_ext_flag     = ext_flag;
        next_pin_dis      = pin_dis;
        next_bod_stop_dis = bod_stop_dis;
        next_clk_ring     = clk_ring;
        next_stat         = stat;
        next_mask         = mask;
        next_fetch        = 1'b0;
        next_warm         = 1'b0;

        // software writes
        if (wr_ctrl)
        begin
            next_sel          = I_PWDATA[CTL_SEL_LSB +: 2];
            next_irq_en       = I_PWDATA[CTL_IRQ_EN];
            next_pin_dis      = I_PWDATA[CTL_PIN_DIS];
            next_bod_stop_dis = I_PWDATA[CTL_BOD_STOP_DIS];
            next_clk_ring     = I_PWDATA[CTL_CLK_RING];
            next_wd_flag      = wd_flag && !I_PWDATA[CTL_WD_FLAG];   // write 1 clears
            next_por_flag     = por_flag && !I_PWDATA[CTL_POR_FLAG];
            next_ext_flag     = ext_flag && !I_PWDATA[CTL_EXT_FLAG];
        end
        if (wr_mask)
            next_mask = I_PWDATA[STA_W-1:0];
        if (rd_stat)
            next_stat = stat & ~prdata[STA_W-1:0];                    // an event after the setup edge survives
        next_stat = next_stat | set_stat;

        // cause flags
        if (src_wd)
            next_wd_flag = 1'b1;
        if (src_ext)
            next_ext_flag = 1'b1;

        // power-on class reset returns every register to its reset value
        if (src_bod)
        begin
            next_por_pend     = 1'b1;
            next_sel          = SEL_RST;
            next_irq_en       = IRQ_EN_RST;
            next_pin_dis      = PIN_DIS_RST;
            next_bod_stop_dis = BOD_STOP_DIS_RST;
            next_clk_ring     = CLK_RING_RST;
            next_wd_flag      = 1'b0;
            next_ext_flag     = 1'b0;
            next_por_flag     = 1'b1;
            next_stat         = STAT_RST;
            next_mask         = MASK_RST;
        end

        // sequencer: hold, then one release cycle, then run
        case (state)
            ST_HOLD:
            begin
                if (any_src)
                    next_hold_cnt = 3'h0;
                else if (hold_cnt == RST_HOLD_CYCLES - 3'h1)
                    next_state = ST_RELEASE;
                else
                    next_hold_cnt = hold_cnt + 3'h1;
            end
            ST_RELEASE:
            begin
                next_hold_cnt = 3'h0;
                if (any_src)
                    next_state = ST_HOLD;
                else
                begin
                    next_state    = ST_RUN;
                    next_fetch    = 1'b1;
                    next_warm     = por_pend;
                    next_por_pend = 1'b0;
                end
            end
            ST_RUN:
            begin
                next_hold_cnt = 3'h0;
                if (any_src)
                    next_state = ST_HOLD;
            end
            default:
            begin
                next_state    = ST_HOLD;
                next_hold_cnt = 3'h0;
            end
        endcase

        next_halt = (next_state != ST_RUN);
        next_irq  = |(next_stat & next_mask);
    end

    // registers; the flags survive watchdog and pin resets so software can read the cause
    always_ff @(posedge I_CLOCK or negedge I_RST_N)
    begin
        if (!I_RST_N)
        begin
            state        <= ST_HOLD;
            hold_cnt     <= 3'h0;
            por_pend     <= 1'b1;
            sel          <= SEL_RST;
            irq_en       <= IRQ_EN_RST;
            wd_flag      <= 1'b0;
            por_flag     <= POR_FLAG_RST;
            ext_flag     <= 1'b0;
            pin_dis      <= PIN_DIS_RST;
            bod_stop_dis <= BOD_STOP_DIS_RST;
            clk_ring     <= CLK_RING_RST;
            stat         <= STAT_RST;
            mask         <= MASK_RST;
            fetch        <= 1'b0;
            warm         <= 1'b0;
            halt         <= 1'b1;
            irq          <= 1'b0;
        end
        else if (I_CE)
        begin
            state        <= next_state;
            hold_cnt     <= next_hold_cnt;
            por_pend     <= next_por_pend;
            sel          <= next_sel;
            irq_en       <= next_irq_en;
            wd_flag      <= next_wd_flag;
            por_flag     <= next_por_flag;
            ext_flag     <= next_ext_flag;
            pin_dis      <= next_pin_dis;
            bod_stop_dis <= next_bod_stop_dis;
            clk_ring     <= next_clk_ring;
            stat         <= next_stat;
            mask         <= next_mask;
            fetch        <= next_fetch;
            warm         <= next_warm;
            halt         <= next_halt;
            irq          <= next_irq;
        end
    end

    // ======================================================================
    // apb read data
    // ======================================================================
    // captured in the setup cycle so the access cycle sees a registered value
    always_comb
    begin
        next_prdata = prdata;
        if (I_PSEL && !I_PENABLE)
        begin
            case (I_PADDR)
                OFF_CTRL: next_prdata = {22'h0, clk_ring, bod_stop_dis, pin_dis, ext_flag,
                                         por_flag, wd_flag, 1'b0, irq_en, sel};
                OFF_STAT: next_prdata = {30'h0, stat};
                OFF_MASK: next_prdata = {30'h0, mask};
                default:  next_prdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge I_CLOCK or negedge I_RST_N)
    begin
        if (!I_RST_N)
            prdata <= 32'h0;
        else if (I_CE)
            prdata <= next_prdata;
    end

    // ======================================================================
    // outputs
    // ======================================================================
    // a frozen block stretches the access rather than dropping it
    assign O_PREADY       = I_CE;
    assign O_PSLVERR      = I_PSEL && I_PENABLE &&
                            (I_PADDR != OFF_CTRL) && (I_PADDR != OFF_STAT) && (I_PADDR != OFF_MASK);
    assign O_PRDATA       = prdata;
    assign O_CPU_HALT     = halt;
    assign O_SYS_RST_N    = !halt;
    assign O_FETCH_START  = fetch;
    assign O_FETCH_ADDR   = RESTART_VECTOR;
    assign O_HFOSC_EN     = 1'b1;
    assign O_RINGOSC_EN   = 1'b1;
    assign O_CLK_SEL_RING = clk_ring;
    assign O_WARMUP_START = warm;
    assign O_RSTPIN_GPIO  = pin_dis;
    assign O_IRQ          = irq;

endmodule

/* File: test/rwdc_asserts.sv */
`timescale 1ns/100ps
// ====
// reset sequencing checks on the top ports
module rwdc_asserts
(
    // clock and reset
    input wire logic        I_CLOCK,
    input wire logic        I_RST_N,
    // reset sources
    input wire logic        I_SUPPLY_OK,
    input wire logic        I_STOP_MODE,
    input wire logic        I_EXT_RST_N,
    // core side
    input wire logic        O_CPU_HALT,
    input wire logic        O_SYS_RST_N,
    input wire logic        O_FETCH_START,
    input wire logic [15:0] O_FETCH_ADDR,
    input wire logic        O_HFOSC_EN,
    input wire logic        O_RINGOSC_EN,
    input wire logic        O_CLK_SEL_RING,
    input wire logic        O_WARMUP_START,
    input wire logic        O_RSTPIN_GPIO
);
    default clocking @(posedge I_CLOCK); endclocking
    default disable iff (!I_RST_N);

    // oscillators must survive every reset
    a_osc_running: assert property (O_HFOSC_EN && O_RINGOSC_EN) else $error("oscillator off");
    a_halt_pair: assert property (O_SYS_RST_N == !O_CPU_HALT) else $error("halt and reset split");
    a_fetch_vector: assert property (O_FETCH_START |-> O_FETCH_ADDR == 16'h8000)
        else $error("wrong restart vector");
    a_fetch_release: assert property ($fell(O_CPU_HALT) |-> O_FETCH_START)
        else $error("no fetch at release");
    a_warm_ring: assert property (O_WARMUP_START |-> O_FETCH_START && O_CLK_SEL_RING)
        else $error("warmup without ring clock");
    // two sync stages plus the halt register, so three edges with one spare
    a_pin_reset: assert property ($fell(I_EXT_RST_N) && !O_RSTPIN_GPIO |-> ##[1:4] O_CPU_HALT)
        else $error("pin reset missed");
    a_supply_reset: assert property ($fell(I_SUPPLY_OK) && !I_STOP_MODE |-> ##[1:4] O_CPU_HALT)
        else $error("brownout missed");
    a_hold_sync: assert property ($rose(I_EXT_RST_N) && O_CPU_HALT |-> O_CPU_HALT[*4])
        else $error("release not synchronised");

    // main scenarios
    c_release: cover property ($fell(O_CPU_HALT));
    c_warmup: cover property (O_WARMUP_START);
    c_pin_free: cover property ($fell(I_EXT_RST_N) && O_RSTPIN_GPIO);
endmodule

bind rwdc_top rwdc_asserts i_rwdc_asserts (.I_CLOCK(I_CLOCK), .I_RST_N(I_RST_N),
    .I_SUPPLY_OK(I_SUPPLY_OK), .I_STOP_MODE(I_STOP_MODE), .I_EXT_RST_N(I_EXT_RST_N),
    .O_CPU_HALT(O_CPU_HALT), .O_SYS_RST_N(O_SYS_RST_N), .O_FETCH_START(O_FETCH_START),
    .O_FETCH_ADDR(O_FETCH_ADDR), .O_HFOSC_EN(O_HFOSC_EN), .O_RINGOSC_EN(O_RINGOSC_EN),
    .O_CLK_SEL_RING(O_CLK_SEL_RING), .O_WARMUP_START(O_WARMUP_START), .O_RSTPIN_GPIO(O_RSTPIN_GPIO));

/* File: test/rwdc_ext_model.sv */
`timescale 1ns/100ps
// ====
// stand-in for the reset pin and the supply monitor
module rwdc_ext_model
(
    // clock
    input  wire logic i_clk,
    // driven lines
    output logic      o_ext_rst_n,
    output logic      o_supply_ok
);
    // pin has a pull-up, so released means high
    initial
    begin
        o_ext_rst_n = 1'b1;
        o_supply_ok = 1'b1;
    end

    // hold one line low for n edges; the pin is only pulled once the bench has started up
    task automatic pulse(input bit brown, input int n);
        @(posedge i_clk);
        if (brown)
            o_supply_ok <= 1'b0;
        else
            o_ext_rst_n <= 1'b0;
        repeat (n) @(posedge i_clk);
        o_supply_ok <= 1'b1;
        o_ext_rst_n <= 1'b1;
    endtask
endmodule

/* File: test/rwdc_top_tb_top.sv */
`timescale 1ns/100ps
// ====
// bench for the reset and watchdog block
module rwdc_top_tb_top import rwdc_pkg::*;;
    localparam int EXP [4] = '{10, 11, 12, 13};
    logic        clk, rst_n, psel, penable, pwrite, perr, w, stop;
    logic        pready, slverr, halt, fetch, ring, warm, gpio, irq, ext_n, sup_ok;
    logic [7:0]  paddr;
    logic [15:0] faddr;
    logic [31:0] pwdata, prdata, r;
    int          err_count, compares, n;

    // 40 MHz system clock
    always #12.5 clk = ~clk;

    rwdc_top #(.P_WD_EXP0(EXP[0]), .P_WD_EXP1(EXP[1]), .P_WD_EXP2(EXP[2]), .P_WD_EXP3(EXP[3])) i_rwdc_top (
        .I_CLOCK(clk), .I_RST_N(rst_n), .I_CE(1'b1), .I_PSEL(psel), .I_PENABLE(penable),
        .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
        .O_PSLVERR(slverr), .I_SUPPLY_OK(sup_ok), .I_STOP_MODE(stop), .I_EXT_RST_N(ext_n),
        .O_CPU_HALT(halt), .O_SYS_RST_N(), .O_FETCH_START(fetch), .O_FETCH_ADDR(faddr), .O_HFOSC_EN(),
        .O_RINGOSC_EN(), .O_CLK_SEL_RING(ring), .O_WARMUP_START(warm), .O_RSTPIN_GPIO(gpio), .O_IRQ(irq));
    rwdc_ext_model i_rwdc_ext_model (.i_clk(clk), .o_ext_rst_n(ext_n), .o_supply_ok(sup_ok));

    // ====
    // helpers
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e)
        begin
            err_count++;
            $display("Error t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    // apb transfer held until pready is seen at an edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, a, d};
        @(posedge clk);
        penable <= 1'b1;
        do
            @(posedge clk);
        while (pready !== 1'b1);
        r = prdata;
        perr = slverr;
        {psel, penable} <= 2'h0;
    endtask

    // bounded wait on halt (0), fetch (1) or irq (2)
    task automatic wait_on(input int k, input int lim);
        n = 0;
        while ((k == 0 ? halt : k == 1 ? fetch : irq) !== 1'b1 && n < lim)
        begin
            @(posedge clk);
            n++;
        end
    endtask

    task automatic to_run();
        wait_on(1, 80);
        w = warm;
        chk(32'(fetch), 1);
        chk(32'(faddr), 32'h8000);
    endtask

    // ====
    // scenarios
    task automatic t_por();
        to_run();
        chk(32'(w), 1);
        chk({30'h0, ring, gpio}, 32'h2);
        apb(0, OFF_CTRL, 0);
        chk(r, 32'h220);
        apb(1, OFF_CTRL, 32'h220);
        apb(0, 8'h0c, 0);
        chk({perr, r[30:0]}, 32'h80000000);
        $display("done t_por");
    endtask

    task automatic t_ext();
        i_rwdc_ext_model.pulse(0, 6);
        chk(32'(halt), 1);
        to_run();
        chk(32'(w), 0);
        apb(0, OFF_CTRL, 0);
        chk(r, 32'h240);
        apb(1, OFF_CTRL, 32'h2c0);
        @(posedge clk);
        chk(32'(gpio), 1);
        i_rwdc_ext_model.pulse(0, 6);
        repeat (6) @(posedge clk);
        chk(32'(halt), 0);
        $display("done t_ext");
    endtask

    // restarts keep it alive, then early interrupt leads the reset
    task automatic t_wdog();
        apb(1, OFF_CTRL, 32'h20c);
        apb(1, OFF_MASK, 32'h1);
        repeat (3)
        begin
            // restart well before the early point, so no interrupt yet
            repeat (400) @(posedge clk);
            apb(1, OFF_CTRL, 32'h20c);
        end
        chk(32'(halt), 0);
        wait_on(2, 1100);
        chk(32'(irq), 1);
        wait_on(0, 600);
        chk(32'(n), WD_EARLY);
        to_run();
        chk(32'(w), 0);
        apb(0, OFF_CTRL, 0);
        chk(r, 32'h214);
        apb(0, OFF_STAT, 0);
        chk(r, 32'h1);
        apb(0, OFF_STAT, 0);
        @(posedge clk);
        chk({irq, r[30:0]}, 32'h0);
        apb(1, OFF_CTRL, 32'h210);
        $display("done t_wdog");
    endtask

    task automatic t_sel();
        for (int s = 0; s < 4; s++)
        begin
            apb(1, OFF_CTRL, 32'h208 | 32'(s));
            wait_on(0, 9000);
            chk(32'(n >= (1 << EXP[s]) - 3 && n <= (1 << EXP[s]) + 3), 1);
            to_run();
        end
        $display("done t_sel");
    endtask

    task automatic t_brown();
        apb(1, OFF_CTRL, 32'h0);
        i_rwdc_ext_model.pulse(1, 4);
        chk({ring, halt}, 32'h3);
        to_run();
        chk({w, ring}, 32'h3);
        apb(0, OFF_CTRL, 0);
        chk(r, 32'h220);
        // supply dip in stop mode with brownout ignored: no reset, only a status event
        stop <= 1'b1;
        apb(1, OFF_CTRL, 32'h300);
        i_rwdc_ext_model.pulse(1, 4);
        chk(32'(halt), 0);
        apb(0, OFF_STAT, 0);
        chk(r, 32'h2);
        stop <= 1'b0;
        $display("done t_brown");
    endtask

    task automatic print_verdict();
        $display("compares=%0d err_count=%0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // main sequence
    initial
    begin
        {clk, rst_n, psel, penable, pwrite, paddr, pwdata, stop} = '0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        t_por();
        t_ext();
        t_wdog();
        t_sel();
        t_brown();
        print_verdict();
    end

    // hang guard, over three times the expected run
    initial
    begin
        #1500000;
        err_count++;
        print_verdict();
    end
endmodule
